// ===== wdw_core_model.sv
// Purpose: Processor core stand-in that issues clear and halt instructions.
// Assumes: Each instruction is a one-cycle pulse launched after a rising edge.
// Notes:   Never issues both instructions in the same cycle.
`timescale 1ns/1ns
`default_nettype none
module wdw_core_model (
    input  wire logic i_clk,
    output logic      o_clear_watchdog_instruction,
    output logic      o_halt
);
    // ----------------------------------------------------------------
    // Instruction issue
    // ----------------------------------------------------------------
    // Idle from time zero so nothing is seen before the first call
    initial begin
        o_clear_watchdog_instruction = 1'h0;
        o_halt    = 1'h0;
    end

    // The clear instruction restarts the count; the halt instruction also clears it
    task automatic clear_wdt();
        @(posedge i_clk);
        o_clear_watchdog_instruction <= 1'h1;
        @(posedge i_clk);
        o_clear_watchdog_instruction <= 1'h0;
    endtask

    // Halt pulse; returns at the edge that takes it
    task automatic halt();
        @(posedge i_clk);
        o_halt <= 1'h1;
        @(posedge i_clk);
        o_halt <= 1'h0;
    endtask
endmodule
`default_nettype wire

// ===== wdw_pkg.sv
// Purpose: Shared constants for the watchdog and wake-up block.
// Assumes: 8-bit register port, 100 MHz system clock.
// Notes:   Offsets are register indices on the plain register port.
package wdw_pkg;
    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [3:0] ADDR_WDT_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_RST_CAUSE  = 4'h1;
    localparam logic [3:0] ADDR_STATUS     = 4'h2;
    localparam logic [3:0] ADDR_PA_WAKE_EN = 4'h3;
    localparam logic [7:0] WDT_CTRL_RESET  = 8'h53;
    localparam logic [7:0] PA_WAKE_RESET   = 8'h00;
    // ----------------------------------------------------------------
    // Field layout
    // ----------------------------------------------------------------
    localparam int         KEY_LSB         = 3;
    localparam int         SEL_MSB         = 2;
    localparam int         FAULT_BIT       = 0;
    localparam int         PDF_BIT         = 0;
    localparam int         EXPIRY_BIT      = 1;
    localparam logic [4:0] KEY_DISABLE     = 5'h15;
    localparam logic [4:0] KEY_ENABLE      = 5'h0A;
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int         SYS_CLK_HZ      = 100000000;
    localparam int         LSRC_HZ         = 32000;
    localparam int         LSRC_DIV        = SYS_CLK_HZ / LSRC_HZ;
    localparam int         SRESET_CYCLES   = 16;
    localparam int         RST_PULSE_CYC   = 4;
    localparam int         CNT_W           = 18;
endpackage

// ===== wdw_sync.sv
// Purpose: Two-flop synchroniser for a bus of pin inputs.
// Assumes: Inputs are asynchronous levels.
// Notes:   The first stage feeds only the second.
`timescale 1ns/1ns
`default_nettype none
module wdw_sync #(
    parameter int W = 8,
    parameter logic [W-1:0] INIT = '1
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    logic [W-1:0] meta_q;
    // Two stages, reset to the idle level to avoid false edges
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            meta_q <= INIT;
            o_q    <= INIT;
        end else begin
            meta_q <= i_d;
            o_q    <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ===== wdw_tick.sv
// Purpose: Divides the system clock into a slow-clock enable pulse.
// Assumes: DIV is at least 2.
// Notes:   Stands in for the low-speed RC oscillator.
`timescale 1ns/1ns
`default_nettype none
module wdw_tick #(
    parameter int DIV = 3125
) (
    input  wire logic i_clk,
    input  wire logic i_rst,
    output logic      o_tick
);
    logic [15:0] cnt_q;
    // Free running divider, one-cycle pulse at wrap
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt_q  <= 16'h0000;
            o_tick <= 1'b0;
        end else if (cnt_q == 16'(DIV - 1)) begin
            cnt_q  <= 16'h0000;
            o_tick <= 1'b1;
        end else begin
            cnt_q  <= cnt_q + 16'h0001;
            o_tick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ===== wdw_top.sv
// What this block does
// RQ1 - Watchdog counts slow RC clock, power-of-two timeout
// RQ2 - Period select maps to divisors 2^8..2^18
// RQ3 - Key 10101 disables, 01010 enables, else reset
// RQ4 - Illegal key sets key fault flag after delay
// RQ5 - Power-on key 01010, period select 011
// RQ6 - Key fault flag cleared only by software
// RQ7 - Overflow while running: device reset, expiry flag
// RQ8 - Overflow asleep: expiry flag, PC/SP reset, wake
// RQ9 - Counter cleared by fault, clear, halt, pin
// RQ10 - Software restarts counter with clear instruction
// RQ11 - Wake on pin reset, port edge, interrupt, overflow
// RQ12 - Pin wake performs complete system reset
// RQ13 - Power-down flag cleared by power-up/clear, set by halt
// RQ14 - Per-pin Port A wake enable on falling edge
// RQ15 - Disabled or stack-full interrupt resumes after halt
// RQ16 - Enabled interrupt with stack room vectors
// RQ17 - Interrupt pending at halt cannot wake
// RQ18 - Halt clears counter; runs only if enabled
// RQ19 - Halt sets power-down flag, clears expiry flag
// RQ20 - Illegal key reset delay is a parameter
//
// Purpose: Watchdog timer with sleep wake-up control.
// Assumes: I_SRST is power-on reset; core gives one-cycle instruction pulses.
// Notes:   Register reads return data one cycle after the read strobe.
//
// Chosen here: the address map and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
module wdw_top #(
    parameter int LSRC_DIV      = wdw_pkg::LSRC_DIV,
    parameter int SRESET_CYCLES = wdw_pkg::SRESET_CYCLES,
    parameter int N_IRQ         = 4
) (
    input  wire logic             I_MCLK,
    input  wire logic             I_SRST,
    input  wire logic [3:0]       I_ADDR,
    input  wire logic [7:0]       I_WDATA,
    input  wire logic             I_WR,
    input  wire logic             I_RD,
    output logic      [7:0]       O_RDATA,
    input  wire logic             I_CLEAR_WATCHDOG_INSTRUCTION,
    input  wire logic             I_HALT,
    input  wire logic             I_EXT_RST_PIN_N,
    input  wire logic [7:0]       I_PORT_A,
    input  wire logic [N_IRQ-1:0] I_IRQ_REQ,
    input  wire logic [N_IRQ-1:0] I_IRQ_EN,
    input  wire logic             I_STACK_FULL,
    output logic                  O_DEV_RST,
    output logic                  O_FULL_RST,
    output logic                  O_PC_SP_RST,
    output logic                  O_WAKE,
    output logic                  O_VECTOR,
    output logic                  O_SLEEPING
);
    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [7:0]             ctrl_q;
    logic [7:0]             pa_wake_en_q;
    logic                   fault_flag_q;
    logic                   pdf_q;
    logic                   expiry_q;
    logic                   asleep_q;
    logic [wdw_pkg::CNT_W-1:0] cnt_q;
    logic                   tick;
    logic                   rst_pin_n;
    logic [7:0]             port_a;
    logic [7:0]             port_a_prev_q;
    logic [N_IRQ-1:0]       irq_mask_q;
    logic [15:0]            sreset_cnt_q;
    logic                   key_bad_q;
    logic                   sreset_fire;
    logic [2:0]             rst_hold_q;
    logic [4:0]             key;
    logic [2:0]             sel;
    logic                   wdt_en;
    logic                   key_bad;
    logic                   overflow;
    logic                   pin_wake;
    logic                   irq_wake;
    logic                   clr_cnt;
    logic                   do_rst;

    assign key     = ctrl_q[7:wdw_pkg::KEY_LSB];
    assign sel     = ctrl_q[wdw_pkg::SEL_MSB:0];
    assign wdt_en  = (key == wdw_pkg::KEY_ENABLE);
    assign key_bad = !wdt_en && (key != wdw_pkg::KEY_DISABLE);   // [RQ3]

    // Time-out count for a period select value
    function automatic logic [wdw_pkg::CNT_W-1:0] limit_of(input logic [2:0] s);
        logic [4:0] sh;
        sh = 5'd0;
        case (s)                                              // [RQ2]
            3'h0:    sh = 5'd8;
            3'h1:    sh = 5'd10;
            3'h2:    sh = 5'd12;
            3'h3:    sh = 5'd14;
            3'h4:    sh = 5'd15;
            3'h5:    sh = 5'd16;
            3'h6:    sh = 5'd17;
            default: sh = 5'd18;
        endcase
        limit_of = wdw_pkg::CNT_W'((19'h00001 << sh) - 19'h00001);
    endfunction

    // ----------------------------------------------------------------
    // Slow clock and pin synchronisers
    // ----------------------------------------------------------------
    wdw_tick #(.DIV(LSRC_DIV)) u_tick (
        .i_clk  (I_MCLK),
        .i_rst  (I_SRST),
        .o_tick (tick)
    );

    wdw_sync #(.W(9), .INIT(9'h1FF)) u_sync (
        .i_clk (I_MCLK),
        .i_rst (I_SRST),
        .i_d   ({I_EXT_RST_PIN_N, I_PORT_A}),
        .o_q   ({rst_pin_n, port_a})
    );

    // Falling edge on an enabled Port A pin wakes the device
    always_ff @(posedge I_MCLK) begin
        if (I_SRST) begin
            port_a_prev_q <= 8'hFF;
        end else begin
            port_a_prev_q <= port_a;
        end
    end
    assign pin_wake = |(port_a_prev_q & ~port_a & pa_wake_en_q);    // [RQ14]

    // Only requests that rose after halt may wake; pending ones are masked
    always_ff @(posedge I_MCLK) begin
        if (I_SRST) begin
            irq_mask_q <= '0;
        end else if (I_HALT) begin
            irq_mask_q <= I_IRQ_REQ;                              // [RQ17]
        end else if (!asleep_q) begin
            irq_mask_q <= '0;
        end
    end
    assign irq_wake = |(I_IRQ_REQ & ~irq_mask_q);

    // ----------------------------------------------------------------
    // Watchdog counter
    // ----------------------------------------------------------------
    // At or above the limit, so a shorter period chosen mid-count cannot miss
    assign overflow = wdt_en && tick && (cnt_q >= limit_of(sel));
    assign clr_cnt  = sreset_fire || I_CLEAR_WATCHDOG_INSTRUCTION || I_HALT || !rst_pin_n; // [RQ9] [RQ10]

    // Counts slow ticks; stops while disabled
    always_ff @(posedge I_MCLK) begin
        if (I_SRST || clr_cnt || overflow) begin
            cnt_q <= '0;                                          // [RQ18]
        end else if (wdt_en && tick) begin
            cnt_q <= cnt_q + 1'b1;                                // [RQ1]
        end
    end

    // Illegal key: wait the software reset delay, then reset
    always_ff @(posedge I_MCLK) begin
        if (I_SRST || !key_bad) begin
            key_bad_q    <= 1'b0;
            sreset_cnt_q <= 16'h0000;
        end else if (!key_bad_q) begin
            key_bad_q    <= 1'b1;
            sreset_cnt_q <= 16'(SRESET_CYCLES - 1);               // [RQ20]
        end else if (sreset_cnt_q != 16'h0000) begin
            sreset_cnt_q <= sreset_cnt_q - 16'h0001;
        end
    end
    assign sreset_fire = key_bad_q && (sreset_cnt_q == 16'h0000);

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    // Control; illegal-key reset restores the power-on value so it fires once
    always_ff @(posedge I_MCLK) begin
        if (I_SRST || sreset_fire) begin
            ctrl_q <= wdw_pkg::WDT_CTRL_RESET;                    // [RQ5]
        end else if (I_WR && I_ADDR == wdw_pkg::ADDR_WDT_CTRL) begin
            ctrl_q <= I_WDATA;
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (I_SRST) begin
            pa_wake_en_q <= wdw_pkg::PA_WAKE_RESET;
        end else if (I_WR && I_ADDR == wdw_pkg::ADDR_PA_WAKE_EN) begin
            pa_wake_en_q <= I_WDATA;
        end
    end

    // Fault flag: hardware sets, software clears, set wins
    always_ff @(posedge I_MCLK) begin
        if (I_SRST) begin
            fault_flag_q <= 1'b0;
        end else if (sreset_fire) begin
            fault_flag_q <= 1'b1;                                 // [RQ4]
        end else if (I_WR && I_ADDR == wdw_pkg::ADDR_RST_CAUSE
                     && !I_WDATA[wdw_pkg::FAULT_BIT]) begin
            fault_flag_q <= 1'b0;                                 // [RQ6]
        end
    end

    // Power-down flag
    always_ff @(posedge I_MCLK) begin
        if (I_SRST) begin
            pdf_q <= 1'b0;
        end else if (I_HALT) begin
            pdf_q <= 1'b1;                                        // [RQ13] [RQ19]
        end else if (I_CLEAR_WATCHDOG_INSTRUCTION) begin
            pdf_q <= 1'b0;                                        // [RQ13]
        end
    end

    // Expiry flag: set by overflow, cleared on halt
    always_ff @(posedge I_MCLK) begin
        if (I_SRST) begin
            expiry_q <= 1'b0;
        end else if (overflow) begin
            expiry_q <= 1'b1;                                     // [RQ7] [RQ8]
        end else if (I_HALT) begin
            expiry_q <= 1'b0;                                     // [RQ19]
        end
    end

    // Read data one cycle after the strobe; unmapped reads zero
    always_ff @(posedge I_MCLK) begin
        if (I_SRST) begin
            O_RDATA <= 8'h00;
        end else if (I_RD) begin
            case (I_ADDR)
                wdw_pkg::ADDR_WDT_CTRL:   O_RDATA <= ctrl_q;
                wdw_pkg::ADDR_RST_CAUSE:  O_RDATA <= {7'h00, fault_flag_q};
                wdw_pkg::ADDR_STATUS:     O_RDATA <= {6'h00, expiry_q, pdf_q};
                wdw_pkg::ADDR_PA_WAKE_EN: O_RDATA <= pa_wake_en_q;
                default:                  O_RDATA <= 8'h00;
            endcase
        end else begin
            O_RDATA <= 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // Sleep, wake and reset outputs
    // ----------------------------------------------------------------
    always_ff @(posedge I_MCLK) begin
        if (I_SRST) begin
            asleep_q <= 1'b0;
        end else if (I_HALT) begin
            asleep_q <= 1'b1;
        end else if (asleep_q && (pin_wake || irq_wake || overflow
                     || !rst_pin_n)) begin
            asleep_q <= 1'b0;                                     // [RQ11]
        end
    end

    // Wake strobe; vectoring only if interrupt enabled and stack free
    always_ff @(posedge I_MCLK) begin
        if (I_SRST) begin
            O_WAKE   <= 1'b0;
            O_VECTOR <= 1'b0;
        end else begin
            O_WAKE   <= asleep_q && !I_HALT && (pin_wake || irq_wake || overflow
                        || !rst_pin_n);
            O_VECTOR <= asleep_q && !I_HALT && rst_pin_n && !overflow
                        && |(I_IRQ_REQ & ~irq_mask_q & I_IRQ_EN)
                        && !I_STACK_FULL;                         // [RQ15] [RQ16]
        end
    end

    // Partial reset for a sleeping overflow, device reset otherwise
    assign do_rst = (overflow && !asleep_q) || sreset_fire;
    always_ff @(posedge I_MCLK) begin
        if (I_SRST) begin
            rst_hold_q  <= 3'h0;
            O_PC_SP_RST <= 1'b0;
        end else begin
            O_PC_SP_RST <= overflow && asleep_q;                  // [RQ8]
            if (do_rst) begin
                rst_hold_q <= 3'(wdw_pkg::RST_PULSE_CYC);         // [RQ7]
            end else if (rst_hold_q != 3'h0) begin
                rst_hold_q <= rst_hold_q - 3'h1;
            end
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (I_SRST) begin
            O_DEV_RST  <= 1'b0;
            O_FULL_RST <= 1'b0;
            O_SLEEPING <= 1'b0;
        end else begin
            O_DEV_RST  <= do_rst || (rst_hold_q > 3'h1);
            O_FULL_RST <= !rst_pin_n;                             // [RQ12]
            O_SLEEPING <= asleep_q;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    fault_set_a: assert property (@(posedge I_MCLK) disable iff (I_SRST) // [RQ4]
        sreset_fire |=> fault_flag_q) else $error("fault flag not set");
    fault_hold_a: assert property (@(posedge I_MCLK) disable iff (I_SRST) // [RQ6]
        (fault_flag_q && !(I_WR && I_ADDR == wdw_pkg::ADDR_RST_CAUSE)) |=> fault_flag_q)
        else $error("fault flag cleared by hardware");
    halt_flags_a: assert property (@(posedge I_MCLK) disable iff (I_SRST) // [RQ19]
        (I_HALT && !overflow) |=> (pdf_q && !expiry_q)) else $error("halt flags wrong");
    clr_pdf_a: assert property (@(posedge I_MCLK) disable iff (I_SRST) // [RQ13]
        (I_CLEAR_WATCHDOG_INSTRUCTION && !I_HALT) |=> !pdf_q) else $error("pdf not cleared");
    cnt_clear_a: assert property (@(posedge I_MCLK) disable iff (I_SRST) // [RQ9]
        clr_cnt |=> (cnt_q == '0)) else $error("counter not cleared");
    cnt_stop_a: assert property (@(posedge I_MCLK) disable iff (I_SRST) // [RQ18]
        (!wdt_en) |=> (cnt_q == '0 || $stable(cnt_q))) else $error("counter ran disabled");
    wdt_rst_a: assert property (@(posedge I_MCLK) disable iff (I_SRST) // [RQ7]
        (overflow && !asleep_q) |=> (O_DEV_RST && expiry_q)) else $error("no reset on overflow");
    sleep_ovf_a: assert property (@(posedge I_MCLK) disable iff (I_SRST) // [RQ8]
        (overflow && asleep_q && !I_HALT) |=> (O_PC_SP_RST && !O_DEV_RST && !asleep_q))
        else $error("sleep overflow wrong");
    key_delay_a: assert property (@(posedge I_MCLK) disable iff (I_SRST) // [RQ3]
        $rose(key_bad_q) |-> !sreset_fire) else $error("key reset too early");
endmodule
`default_nettype wire

// ===== wdw_top_tb_top.sv
// Purpose: Self-checking bench for the watchdog and wake-up block.
// Assumes: Short slow-clock divider and short key-fault delay for run time.
// Notes:   Only the two shortest periods are timed; the rest read back only.
`timescale 1ns/1ns
`default_nettype none
module wdw_top_tb_top;
    localparam int DIV = 4;
    localparam int SRD = 4;
    localparam int EXP_TAB [8] = '{8, 10, 12, 14, 15, 16, 17, 18};

    logic       mclk;
    logic       srst;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;
    logic       clear_watchdog_instruction;
    logic       halt;
    logic       pin_n;
    logic [7:0] port_a;
    logic [3:0] irq_req;
    logic [3:0] irq_en;
    logic       stack_full;
    logic       dev_rst, full_rst, pc_sp_rst, wake, vector, sleeping;
    logic [4:0] seen;
    logic [7:0] rv;
    int         fail_count;
    int         checks_done;

    wdw_top #(.LSRC_DIV(DIV), .SRESET_CYCLES(SRD), .N_IRQ(4)) wdw_top_inst (
        .I_MCLK(mclk), .I_SRST(srst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
        .I_RD(rd), .O_RDATA(rdata), .I_CLEAR_WATCHDOG_INSTRUCTION(clear_watchdog_instruction), .I_HALT(halt),
        .I_EXT_RST_PIN_N(pin_n), .I_PORT_A(port_a), .I_IRQ_REQ(irq_req),
        .I_IRQ_EN(irq_en), .I_STACK_FULL(stack_full), .O_DEV_RST(dev_rst),
        .O_FULL_RST(full_rst), .O_PC_SP_RST(pc_sp_rst), .O_WAKE(wake),
        .O_VECTOR(vector), .O_SLEEPING(sleeping));

    wdw_core_model wdw_core_model_inst (.i_clk(mclk), .o_clear_watchdog_instruction(clear_watchdog_instruction), .o_halt(halt));

    // ----------------------------------------------------------------
    // Bus, watch and compare helpers
    // ----------------------------------------------------------------
    initial begin
        mclk = 1'h0;
        forever #5 mclk = ~mclk;
    end

    task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
        checks_done++;
        if (s !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic flag(input string n, input logic s, input logic e);
        check(n, {7'h00, s}, {7'h00, e});
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'h1;
        @(posedge mclk);
        wr <= 1'h0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample there
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        rd   <= 1'h1;
        @(posedge mclk);
        rd <= 1'h0;
        #1;
        d = rdata;
    endtask

    // Wake, vector and PC/SP reset pulses are one cycle long, so collect them over a span
    task automatic watch(input int n);
        seen = 5'h00;
        repeat (n) begin
            @(posedge mclk);
            #1;
            seen = seen | {dev_rst, full_rst, pc_sp_rst, wake, vector};
        end
    endtask

    task automatic do_reset(input int n);
        @(posedge mclk);
        srst <= 1'h1;
        repeat (n) @(posedge mclk);
        srst <= 1'h0;
    endtask

    // Tick phase is unknown, so the overflow lands within one tick of 2^n ticks
    task automatic expire(input logic [2:0] sel);
        int span;
        span = (1 << EXP_TAB[sel]) * DIV;
        wr_reg(wdw_pkg::ADDR_WDT_CTRL, {wdw_pkg::KEY_ENABLE, sel});
        wdw_core_model_inst.clear_wdt();
        watch(span - DIV - 3);
        flag("early_rst", seen[4], 1'h0);
        watch(DIV + 8);
        flag("expiry_rst", seen[4], 1'h1);
        rd_reg(wdw_pkg::ADDR_STATUS, rv);
        check("expiry_status", rv, 8'h02);
    endtask

    task automatic irq_wake(input logic full, input logic e_vec);
        @(posedge mclk);
        irq_req    <= 4'h0;
        stack_full <= full;
        wdw_core_model_inst.halt();
        @(posedge mclk);
        irq_req <= 4'h4;
        watch(10);
        flag("irq_wake", seen[1], 1'h1);
        flag("vector", seen[0], e_vec);
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Watchdog sized well above the roughly 14k cycles the tests need
    initial begin
        #(40000 * 10);
        fail_count++;
        stop_test();
    end

    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial begin
        srst = 1'h1;
        {addr, wdata, wr, rd, stack_full, irq_req, irq_en} = '0;
        pin_n = 1'h1;
        port_a = 8'hFF;
        fail_count = 0;
        checks_done = 0;
        do_reset(1);
        rd_reg(wdw_pkg::ADDR_WDT_CTRL, rv);
        check("ctrl_reset", rv, wdw_pkg::WDT_CTRL_RESET);
        rd_reg(wdw_pkg::ADDR_RST_CAUSE, rv);
        check("cause_reset", rv, 8'h00);
        rd_reg(wdw_pkg::ADDR_STATUS, rv);
        check("status_reset", rv, 8'h00);
        rd_reg(wdw_pkg::ADDR_PA_WAKE_EN, rv);
        check("pa_wake_reset", rv, wdw_pkg::PA_WAKE_RESET);
        wr_reg(4'hE, 8'hFF);
        rd_reg(4'hE, rv);
        check("unmapped", rv, 8'h00);
        for (int s = 0; s < 8; s++) begin
            wr_reg(wdw_pkg::ADDR_WDT_CTRL, {wdw_pkg::KEY_ENABLE, 3'(s)});
            rd_reg(wdw_pkg::ADDR_WDT_CTRL, rv);
            check("period_sel", rv, {wdw_pkg::KEY_ENABLE, 3'(s)});
        end
        expire(3'h0);
        expire(3'h1);
        // Sleeping overflow: partial reset and wake, no device reset
        wr_reg(wdw_pkg::ADDR_WDT_CTRL, {wdw_pkg::KEY_ENABLE, 3'h0});
        wdw_core_model_inst.halt();
        // The sleeping output is registered once more after the halt edge
        @(posedge mclk);
        #1;
        flag("asleep", sleeping, 1'h1);
        rd_reg(wdw_pkg::ADDR_STATUS, rv);
        check("halt_status", rv, 8'h01);
        watch(256 * DIV - DIV - 7);
        flag("early_partial", seen[2], 1'h0);
        watch(DIV + 8);
        flag("partial_rst", seen[2], 1'h1);
        flag("wdt_wake", seen[1], 1'h1);
        flag("no_dev_rst", seen[4], 1'h0);
        flag("awake", sleeping, 1'h0);
        rd_reg(wdw_pkg::ADDR_STATUS, rv);
        check("sleep_expiry", rv, 8'h03);
        wdw_core_model_inst.clear_wdt();
        rd_reg(wdw_pkg::ADDR_STATUS, rv);
        check("power_down_clr", rv & 8'h01, 8'h00);
        // Keep-alive by clear instruction
        for (int i = 0; i < 4; i++) begin
            wdw_core_model_inst.clear_wdt();
            watch(800);
            flag("kept_alive", seen[4], 1'h0);
        end
        wr_reg(wdw_pkg::ADDR_WDT_CTRL, {wdw_pkg::KEY_DISABLE, 3'h0});
        watch(2000);
        flag("disabled", seen[4], 1'h0);
        // Disabled watchdog stays stopped in sleep; only the pin wakes it
        wdw_core_model_inst.halt();
        watch(2000);
        flag("stopped_asleep", seen[1], 1'h0);
        @(posedge mclk);
        pin_n <= 1'h0;
        watch(8);
        flag("pin_full_rst", seen[3], 1'h1);
        flag("pin_wake", seen[1], 1'h1);
        @(posedge mclk);
        pin_n <= 1'h1;
        watch(6);
        flag("full_rst_off", full_rst, 1'h0);
        // Illegal key: delayed reset, fault flag, set-only by hardware
        wr_reg(wdw_pkg::ADDR_WDT_CTRL, {5'h1F, 3'h0});
        watch(SRD - 1);
        flag("key_delay", seen[4], 1'h0);
        watch(8);
        flag("key_rst", seen[4], 1'h1);
        rd_reg(wdw_pkg::ADDR_RST_CAUSE, rv);
        check("key_fault", rv, 8'h01);
        rd_reg(wdw_pkg::ADDR_WDT_CTRL, rv);
        check("ctrl_restored", rv, wdw_pkg::WDT_CTRL_RESET);
        wr_reg(wdw_pkg::ADDR_RST_CAUSE, 8'h01);
        rd_reg(wdw_pkg::ADDR_RST_CAUSE, rv);
        check("fault_w1", rv, 8'h01);
        wr_reg(wdw_pkg::ADDR_RST_CAUSE, 8'h00);
        rd_reg(wdw_pkg::ADDR_RST_CAUSE, rv);
        check("fault_w0", rv, 8'h00);
        // Port A wake honours the per-pin enable
        do_reset(3);
        wr_reg(wdw_pkg::ADDR_PA_WAKE_EN, 8'h01);
        wdw_core_model_inst.halt();
        @(posedge mclk);
        port_a <= 8'hFD;
        watch(10);
        flag("pa_masked", seen[1], 1'h0);
        @(posedge mclk);
        port_a <= 8'hFC;
        watch(10);
        flag("pa_wake", seen[1], 1'h1);
        @(posedge mclk);
        port_a <= 8'hFF;
        // Interrupt wake paths
        irq_req <= 4'h1;
        wdw_core_model_inst.halt();
        watch(10);
        flag("pending_masked", seen[1], 1'h0);
        @(posedge mclk);
        irq_req <= 4'h3;
        watch(10);
        flag("dis_irq_wake", seen[1], 1'h1);
        flag("dis_irq_novec", seen[0], 1'h0);
        irq_en <= 4'h4;
        irq_wake(1'h1, 1'h0);
        irq_wake(1'h0, 1'h1);
        stop_test();
    end
endmodule
`default_nettype wire
